/* adcf_pkg.sv */
// constants, state type and pair lookup for the converter input select block
// assumes a word-wide bus with one register per aligned word
package adcf_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_CTRL_B   = 6'h03;
   localparam logic [5:0] IDX_RES_LO   = 6'h04;
   localparam logic [5:0] IDX_RES_HI   = 6'h05;
   localparam logic [5:0] IDX_CTRL_A   = 6'h06;
   localparam logic [5:0] IDX_MUX_SEL  = 6'h07;
   // field positions
   localparam int BIT_ENABLE    = 7;
   localparam int BIT_START     = 6;
   localparam int BIT_DONE      = 4;
   localparam int BIT_BIPOLAR   = 7;
   localparam int REF_MSB       = 7;
   localparam int REF_LSB       = 6;
   localparam int CHAN_MSB      = 5;
   // reset values
   localparam logic [7:0] MUX_SEL_RESET = 8'h00;
   localparam logic [1:0] REF_RESET     = 2'h0;
   localparam logic       FLAG_RESET    = 1'b0;
   // reference codes
   localparam logic [1:0] REF_SUPPLY    = 2'h0;
   localparam logic [1:0] REF_EXT_PIN   = 2'h1;
   localparam logic [1:0] REF_INTERNAL  = 2'h2;
   localparam logic [1:0] REF_INT_TO_PIN = 2'h3;
   // channel codes and pin numbers seen by the analog front end
   localparam logic [5:0] CHAN_GROUND   = 6'h20;
   localparam logic [5:0] CHAN_BANDGAP  = 6'h21;
   localparam logic [5:0] CHAN_TEMP     = 6'h22;
   localparam logic [3:0] PIN_TEMP      = 4'h8;
   localparam logic [3:0] PIN_GROUND    = 4'h9;
   localparam logic [3:0] PIN_BANDGAP   = 4'ha;
   // gains and result limits
   localparam logic [5:0] GAIN_LOW      = 6'h01;
   localparam logic [5:0] GAIN_HIGH     = 6'h14;
   localparam logic [9:0] UNI_MAX       = 10'h3ff;
   localparam logic [9:0] UNI_MIN       = 10'h000;
   localparam logic [9:0] BIP_MAX       = 10'h1ff;
   localparam logic [9:0] BIP_MIN       = 10'h200;
   // conversion lengths in converter clock cycles
   localparam logic [4:0] CONV_CYCLES       = 5'h0d;
   localparam logic [4:0] FIRST_CONV_CYCLES = 5'h19;
   localparam logic [4:0] CONV_OVERHEAD     = 5'h03;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_SAMPLE  = 2'b01,
      ST_CONVERT = 2'b11,
      ST_FINISH  = 2'b10
   } adcf_state_t;

   // forward pair for code bits [4:1]; returns {positive pin, negative pin}
   function automatic logic [5:0] pair_pins(input logic [3:0] idx);
      logic [5:0] p;
      p = 6'h00;
      unique case (idx)
         4'h4:    p = {3'h0, 3'h1};
         4'h5:    p = {3'h0, 3'h3};
         4'h6:    p = {3'h1, 3'h2};
         4'h7:    p = {3'h1, 3'h3};
         4'h8:    p = {3'h2, 3'h3};
         4'h9:    p = {3'h3, 3'h4};
         4'ha:    p = {3'h3, 3'h5};
         4'hb:    p = {3'h3, 3'h6};
         4'hc:    p = {3'h3, 3'h7};
         4'hd:    p = {3'h4, 3'h5};
         4'he:    p = {3'h5, 3'h6};
         4'hf:    p = {3'h6, 3'h7};
         default: p = 6'h00;
      endcase
      return p;
   endfunction
endpackage

/* adcf_sel_if.sv */
// carrier between the select decoder, the result coder and the top
// assumes all three sit on one clock
`timescale 1ns/10ps
interface adcf_sel_if;
   logic [5:0] chan_code;
   logic [3:0] pos_pin;
   logic [3:0] neg_pin;
   logic       differential;
   logic       gain_20x;
   logic       temp_en;
   logic       bipolar;
   logic [9:0] pos_level;
   logic [9:0] neg_level;
   logic [9:0] result;

   modport decoder (input chan_code, output pos_pin, neg_pin, differential, gain_20x, temp_en);
   modport coder   (input differential, gain_20x, bipolar, pos_level, neg_level,
                    output result);
   modport top     (output chan_code, bipolar, pos_level, neg_level,
                    input pos_pin, neg_pin, differential, gain_20x, temp_en, result);
endinterface

/* adcf_chan_decode.sv */
// channel code to front-end pin routing, purely combinational
// assumes the code comes from the active copy, stable during a conversion
`timescale 1ns/10ps
module adcf_chan_decode (
   adcf_sel_if.decoder sel
);
   logic [5:0] pair;

   always_comb begin
      pair             = adcf_pkg::pair_pins(sel.chan_code[4:1]);
      sel.pos_pin      = {1'b0, sel.chan_code[2:0]};
      sel.neg_pin      = adcf_pkg::PIN_GROUND;
      sel.differential = 1'b0;
      sel.gain_20x     = 1'b0;
      sel.temp_en      = 1'b0;
      if (sel.chan_code[5:3] == 3'h0) begin
         sel.pos_pin = {1'b0, sel.chan_code[2:0]};
      end else if (!sel.chan_code[5]) begin
         sel.pos_pin      = {1'b0, pair[5:3]};
         sel.neg_pin      = {1'b0, pair[2:0]};
         sel.differential = 1'b1;
         sel.gain_20x     = sel.chan_code[0];
      end else if (sel.chan_code[4:3] == 2'h0) begin
         unique case (sel.chan_code[2:0])
            3'h0: sel.pos_pin = adcf_pkg::PIN_GROUND;
            3'h1: sel.pos_pin = adcf_pkg::PIN_BANDGAP;
            3'h2: begin
               sel.pos_pin = adcf_pkg::PIN_TEMP;
               sel.temp_en = 1'b1;
            end
            default: begin
               // one pin on both inputs for offset measurement
               sel.pos_pin      = (sel.chan_code[2:1] == 2'h1) ? 4'h0 :
                                  (sel.chan_code[2:1] == 2'h2) ? 4'h3 : 4'h7;
               sel.neg_pin      = sel.pos_pin;
               sel.differential = 1'b1;
               sel.gain_20x     = sel.chan_code[0];
            end
         endcase
      end else begin
         sel.pos_pin      = {1'b0, pair[2:0]};
         sel.neg_pin      = {1'b0, pair[5:3]};
         sel.differential = 1'b1;
         sel.gain_20x     = sel.chan_code[0];
      end
   end
endmodule

/* adcf_result_code.sv */
// turns the held input levels into the 10-bit result word
// assumes levels are already scaled so that 1024 equals the reference
`timescale 1ns/10ps
module adcf_result_code (
   adcf_sel_if.coder sel
);
   logic signed [10:0] diff;
   logic signed [16:0] prod;
   logic signed [16:0] half;
   logic        [5:0]  gain;

   always_comb begin
      gain = sel.gain_20x ? adcf_pkg::GAIN_HIGH : adcf_pkg::GAIN_LOW;
      diff = $signed({1'b0, sel.pos_level}) - $signed({1'b0, sel.neg_level});
      prod = 17'(diff) * $signed({11'h000, gain});
      half = prod >>> 1;
      if (!sel.differential) begin
         sel.result = sel.pos_level;
      end else if (!sel.bipolar) begin
         if (prod < 0) begin
            sel.result = adcf_pkg::UNI_MIN;
         end else if (prod > 17'sh003ff) begin
            sel.result = adcf_pkg::UNI_MAX;
         end else begin
            sel.result = prod[9:0];
         end
      end else begin
         // halving gives the 512 scale; bit 9 then carries the sign
         if (half > 17'sh001ff) begin
            sel.result = adcf_pkg::BIP_MAX;
         end else if (half < -17'sh00200) begin
            sel.result = adcf_pkg::BIP_MIN;
         end else begin
            sel.result = half[9:0];
         end
      end
   end
endmodule

/* adcf_top.sv */
// converter input select, reference select and result coding behind a wishbone slave
// assumes the analog front end samples its levels on clk_i (one domain)
`timescale 1ns/10ps
module adcf_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [9:0]  pos_level_i,
   input  wire logic [9:0]  neg_level_i,
   output logic      [3:0]  pos_pin_o,
   output logic      [3:0]  neg_pin_o,
   output logic             differential_o,
   output logic             gain_20x_o,
   output logic             temp_sensor_en_o,
   output logic      [1:0]  ref_select_o,
   output logic             internal_ref_on_o,
   output logic             ref_pin_connect_o,
   output logic             sample_o,
   output logic             busy_o
);
   adcf_sel_if sel ();

   adcf_pkg::adcf_state_t state_reg;
   logic [7:0]  mux_reg;
   logic [5:0]  active_chan_reg;
   logic [1:0]  active_ref_reg;
   logic        bipolar_reg;
   logic        enable_reg;
   logic        first_pending_reg;
   logic        done_flag_reg;
   logic [4:0]  count_reg;
   logic [9:0]  hold_pos_reg;
   logic [9:0]  hold_neg_reg;
   logic [9:0]  result_reg;
   logic        ack_reg;
   logic [31:0] dat_reg;
   logic [31:0] read_word;
   logic [5:0]  idx;
   logic        wr_go;
   logic        start_go;
   logic [4:0]  start_len;

   adcf_chan_decode u_decode (
      .sel (sel.decoder)
   );

   adcf_result_code u_code (
      .sel (sel.coder)
   );

   assign sel.chan_code = active_chan_reg;
   assign sel.bipolar   = bipolar_reg;
   assign sel.pos_level = hold_pos_reg;
   assign sel.neg_level = hold_neg_reg;

   assign idx       = wb_adr_i[7:2];
   // write lands on the edge where the master sees ack
   assign wr_go     = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
   assign start_go  = wr_go && (idx == adcf_pkg::IDX_CTRL_A) &&
                      wb_dat_i[adcf_pkg::BIT_ENABLE] && wb_dat_i[adcf_pkg::BIT_START] &&
                      (state_reg == adcf_pkg::ST_IDLE);
   assign start_len = (first_pending_reg || !enable_reg) ?
                      adcf_pkg::FIRST_CONV_CYCLES : adcf_pkg::CONV_CYCLES;

   always_comb begin
      read_word = 32'h00000000;
      unique case (idx)
         adcf_pkg::IDX_MUX_SEL: read_word[7:0] = mux_reg;
         adcf_pkg::IDX_CTRL_B:  read_word[adcf_pkg::BIT_BIPOLAR] = bipolar_reg;
         adcf_pkg::IDX_RES_LO:  read_word[7:0] = result_reg[7:0];
         adcf_pkg::IDX_RES_HI:  read_word[1:0] = result_reg[9:8];
         adcf_pkg::IDX_CTRL_A: begin
            read_word[adcf_pkg::BIT_ENABLE] = enable_reg;
            read_word[adcf_pkg::BIT_START]  = (state_reg != adcf_pkg::ST_IDLE);
            read_word[adcf_pkg::BIT_DONE]   = done_flag_reg;
         end
         default:               read_word = 32'h00000000;
      endcase
   end

   // bus handshake: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
         if (wb_cyc_i && wb_stb_i && !ack_reg) begin
            dat_reg <= read_word;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mux_reg <= adcf_pkg::MUX_SEL_RESET;
      end else if (wr_go && idx == adcf_pkg::IDX_MUX_SEL) begin
         mux_reg <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bipolar_reg <= 1'b0;
      end else if (wr_go && idx == adcf_pkg::IDX_CTRL_B) begin
         bipolar_reg <= wb_dat_i[adcf_pkg::BIT_BIPOLAR];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_reg        <= 1'b0;
         first_pending_reg <= 1'b0;
      end else begin
         if (wr_go && idx == adcf_pkg::IDX_CTRL_A) begin
            enable_reg <= wb_dat_i[adcf_pkg::BIT_ENABLE];
         end
         // the first run after enabling is the long initialising one
         if (start_go) begin
            first_pending_reg <= 1'b0;
         end else if (!enable_reg) begin
            first_pending_reg <= 1'b1;
         end
      end
   end

   // conversion sequencer; clearing enable aborts a run in progress
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= adcf_pkg::ST_IDLE;
         count_reg <= 5'h00;
      end else if (!enable_reg && state_reg != adcf_pkg::ST_IDLE) begin
         state_reg <= adcf_pkg::ST_IDLE;
         count_reg <= 5'h00;
      end else begin
         unique case (state_reg)
            adcf_pkg::ST_IDLE: begin
               if (start_go) begin
                  state_reg <= adcf_pkg::ST_SAMPLE;
                  count_reg <= start_len - adcf_pkg::CONV_OVERHEAD;
               end
            end
            adcf_pkg::ST_SAMPLE: state_reg <= adcf_pkg::ST_CONVERT;
            adcf_pkg::ST_CONVERT: begin
               if (count_reg == 5'h00) begin
                  state_reg <= adcf_pkg::ST_FINISH;
               end else begin
                  count_reg <= count_reg - 5'h01;
               end
            end
            adcf_pkg::ST_FINISH: state_reg <= adcf_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_pos_reg <= 10'h000;
         hold_neg_reg <= 10'h000;
      end else if (state_reg == adcf_pkg::ST_SAMPLE) begin
         hold_pos_reg <= pos_level_i;
         hold_neg_reg <= neg_level_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_reg <= 10'h000;
      end else if (state_reg == adcf_pkg::ST_FINISH) begin
         result_reg <= sel.result;
      end
   end

   // a completion in the same cycle as a write-one clear keeps the flag set
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_flag_reg <= adcf_pkg::FLAG_RESET;
      end else if (state_reg == adcf_pkg::ST_FINISH) begin
         done_flag_reg <= 1'b1;
      end else if (wr_go && idx == adcf_pkg::IDX_CTRL_A && wb_dat_i[adcf_pkg::BIT_DONE]) begin
         done_flag_reg <= 1'b0;
      end
   end

   // active copy follows the register only while idle or as a run completes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_chan_reg <= adcf_pkg::MUX_SEL_RESET[adcf_pkg::CHAN_MSB:0];
         active_ref_reg  <= adcf_pkg::REF_RESET;
      end else if (state_reg == adcf_pkg::ST_IDLE || state_reg == adcf_pkg::ST_FINISH) begin
         active_chan_reg <= mux_reg[adcf_pkg::CHAN_MSB:0];
         active_ref_reg  <= mux_reg[adcf_pkg::REF_MSB:adcf_pkg::REF_LSB];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_pin_o         <= 4'h0;
         neg_pin_o         <= adcf_pkg::PIN_GROUND;
         differential_o    <= 1'b0;
         gain_20x_o        <= 1'b0;
         temp_sensor_en_o  <= 1'b0;
         ref_select_o      <= adcf_pkg::REF_RESET;
         internal_ref_on_o <= 1'b0;
         ref_pin_connect_o <= 1'b0;
         sample_o          <= 1'b0;
         busy_o            <= 1'b0;
      end else begin
         pos_pin_o         <= sel.pos_pin;
         neg_pin_o         <= sel.neg_pin;
         differential_o    <= sel.differential;
         gain_20x_o        <= sel.gain_20x;
         temp_sensor_en_o  <= sel.temp_en;
         ref_select_o      <= active_ref_reg;
         // reserved code 11 is taken as internal reference tied out to the pin
         internal_ref_on_o <= active_ref_reg[1];
         ref_pin_connect_o <= (active_ref_reg == adcf_pkg::REF_INT_TO_PIN);
         sample_o          <= (state_reg == adcf_pkg::ST_IDLE) && start_go;
         busy_o            <= (state_reg != adcf_pkg::ST_IDLE) || start_go;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_conv_start;
      state_reg == adcf_pkg::ST_IDLE && start_go;
   endsequence

   sequence s_conv_end;
      state_reg == adcf_pkg::ST_FINISH;
   endsequence

   chk_conv_length: assert property (s_conv_start |-> ##[13:25] s_conv_end)
      else $error("conversion did not finish in 13 to 25 cycles");

   chk_done_update: assert property (s_conv_end |=> done_flag_reg &&
                                     result_reg == $past(sel.result))
      else $error("done flag or result not updated at completion");

   chk_chan_frozen: assert property (state_reg != adcf_pkg::ST_IDLE &&
                                     $past(state_reg) != adcf_pkg::ST_IDLE |->
                                     $stable(active_chan_reg))
      else $error("channel changed during conversion");

   chk_ref_frozen: assert property (state_reg != adcf_pkg::ST_IDLE &&
                                    $past(state_reg) != adcf_pkg::ST_IDLE |->
                                    $stable(active_ref_reg))
      else $error("reference changed during conversion");

   chk_idle_follow: assert property (state_reg == adcf_pkg::ST_IDLE &&
                                     $past(state_reg) == adcf_pkg::ST_IDLE |->
                                     active_chan_reg == $past(mux_reg[5:0]))
      else $error("active copy not following register while idle");

   chk_uni_clamp: assert property (s_conv_end and (!bipolar_reg && sel.differential &&
                                   hold_pos_reg < hold_neg_reg) |=> result_reg == 10'h000)
      else $error("unipolar negative difference not clamped to zero");

   chk_uni_scale: assert property (s_conv_end and (!bipolar_reg && sel.differential &&
                                   !sel.gain_20x && hold_pos_reg >= hold_neg_reg) |=>
                                   result_reg == hold_pos_reg - hold_neg_reg)
      else $error("unipolar gain 1 result wrong");

   chk_bip_sign: assert property (s_conv_end and (bipolar_reg && sel.differential) |=>
                                  result_reg[9] == (hold_pos_reg < hold_neg_reg))
      else $error("bipolar sign bit wrong");

   chk_single_map: assert property (active_chan_reg[5:3] == 3'h0 |=>
                                    pos_pin_o == {1'b0, $past(active_chan_reg[2:0])} &&
                                    !differential_o)
      else $error("single-ended code routed wrong");

   chk_temp_route: assert property (active_chan_reg == adcf_pkg::CHAN_TEMP |=>
                                    temp_sensor_en_o && pos_pin_o == adcf_pkg::PIN_TEMP)
      else $error("temperature channel not routed");

   chk_offset_same: assert property (active_chan_reg[5:3] == 3'h4 &&
                                     active_chan_reg[2:0] > 3'h2 |=>
                                     differential_o && pos_pin_o == neg_pin_o)
      else $error("offset code inputs differ");

   chk_pair_swap: assert property (active_chan_reg[5] && active_chan_reg[4:3] != 2'h0 |=>
                                   {neg_pin_o[2:0], pos_pin_o[2:0]} ==
                                   adcf_pkg::pair_pins($past(active_chan_reg[4:1])))
      else $error("reversed pair not swapped");

   chk_ref_pin: assert property (active_ref_reg == adcf_pkg::REF_INT_TO_PIN |=>
                                 ref_pin_connect_o && internal_ref_on_o)
      else $error("reference code 11 not tied to pin");

   chk_fwd_pair: assert property (!active_chan_reg[5] && active_chan_reg[4:3] != 2'h0 |=>
                                  differential_o && {pos_pin_o[2:0], neg_pin_o[2:0]} ==
                                  adcf_pkg::pair_pins($past(active_chan_reg[4:1])))
      else $error("forward pair routed wrong");

   // hold levels cannot move before the next sample state, so no past value is needed
   chk_bip_scale: assert property (s_conv_end and (bipolar_reg && sel.differential &&
                                   !sel.gain_20x) |=> result_reg ==
                                   10'(({1'b0, hold_pos_reg} - {1'b0, hold_neg_reg}) >> 1))
      else $error("bipolar gain 1 result wrong");

   chk_uni_gain20: assert property (s_conv_end and (!bipolar_reg && sel.differential &&
                                    sel.gain_20x && hold_pos_reg >= hold_neg_reg) |=>
                                    result_reg == ((hold_pos_reg - hold_neg_reg > 10'h033) ?
                                    adcf_pkg::UNI_MAX :
                                    10'((hold_pos_reg - hold_neg_reg) * 5'h14)))
      else $error("unipolar gain 20 result wrong");

   chk_gain_sel: assert property (sel.differential |=>
                                  gain_20x_o == $past(active_chan_reg[0]))
      else $error("gain bit not taken from lowest channel bit");

   chk_single_result: assert property (s_conv_end and (!sel.differential) |=>
                                       result_reg == hold_pos_reg)
      else $error("single-ended result not the positive level");
endmodule

/* adcf_front_model.sv */
// analog front end stand-in: a fixed level of its own for every routed pin but bandgap (same as pin 6) and the sensor pin, whose level depends on its enable
// assumes the routing outputs of adcf_top, levels read on the same clock
`timescale 1ns/10ps
module adcf_front_model (
   input  wire logic [3:0] pos_pin_i,
   input  wire logic [3:0] neg_pin_i,
   input  wire logic       temp_en_i,
   output logic      [9:0] pos_level_o,
   output logic      [9:0] neg_level_o
);
   // sensor gives nothing unless enabled, so a missing enable shows in the result
   function automatic logic [9:0] lvl(input logic [3:0] p, input logic t);
      if (p < 4'h8) return {p, 6'h00} + 10'h040;
      if (p == 4'h8) return t ? 10'h13a : 10'h000;
      if (p == 4'ha) return 10'h1c0;
      return 10'h000;
   endfunction
   assign pos_level_o = lvl(pos_pin_i, temp_en_i);
   assign neg_level_o = lvl(neg_pin_i, temp_en_i);
endmodule

/* adcf_top_tb.sv */
// self-checking bench for adcf_top: bus tasks, conversion scenarios, verdict
// assumes adcf_front_model stands in for the analog pins and the sensor
`timescale 1ns/10ps
module adcf_top_tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [31:0] dat   = 32'h0;
   logic [31:0] rdat;
   logic        ack, diff, g20, ten, iref, rcon, smp, busy;
   logic [9:0]  pl, nl;
   logic [3:0]  pp, np;
   logic [1:0]  rs;
   logic [7:0]  hi;
   int          fails = 0;
   int          tests_run = 0;
   int          ticks = 0;
   always #4 clk_i = ~clk_i;
   adcf_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .pos_level_i(pl), .neg_level_i(nl), .pos_pin_o(pp),
      .neg_pin_o(np), .differential_o(diff), .gain_20x_o(g20), .temp_sensor_en_o(ten),
      .ref_select_o(rs), .internal_ref_on_o(iref), .ref_pin_connect_o(rcon),
      .sample_o(smp), .busy_o(busy));
   adcf_front_model fe_u (.pos_pin_i(pp), .neg_pin_i(np), .temp_en_i(ten),
      .pos_level_o(pl), .neg_level_o(nl));
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk_i) begin
      ticks++;
      if (ticks == 8000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // classic cycle: hold everything until ack is sampled, then release
   task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d,
                     output logic [7:0] r);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= {i, 2'b00};
      dat <= {24'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      r = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask
   task automatic settle();
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   task automatic start_wait();
      logic [7:0] r;
      int n;
      n = 0;
      wb(1'b1, adcf_pkg::IDX_CTRL_A, 8'hd0, r);
      do begin
         wb(1'b0, adcf_pkg::IDX_CTRL_A, 8'h00, r);
         n++;
      end while (r[4] !== 1'b1 && n < 40);
      chk("done_flag", 10'h001, {9'h0, r[4]});
      chk("busy_bit", 10'h000, {9'h0, r[6]});
      chk("busy_off", 10'h000, {8'h0, busy, smp});
   endtask
   task automatic conv(input logic [7:0] m, input logic [9:0] e);
      logic [7:0] lo;
      wb(1'b1, adcf_pkg::IDX_MUX_SEL, m, lo);
      repeat (16) @(posedge clk_i);
      start_wait();
      wb(1'b0, adcf_pkg::IDX_RES_LO, 8'h00, lo);
      wb(1'b0, adcf_pkg::IDX_RES_HI, 8'h00, hi);
      chk("result", e, {hi[1:0], lo});
      #1;
   endtask
   task automatic reset_vals();
      logic [7:0] r;
      #1;
      chk("neg_pin_rst", 10'h009, {6'h0, np});
      wb(1'b0, adcf_pkg::IDX_MUX_SEL, 8'h00, r);
      chk("mux_rst", 10'h000, {2'b0, r});
      wb(1'b1, 6'h00, 8'h3f, r);
      wb(1'b0, 6'h00, 8'h00, r);
      chk("unmapped", 10'h000, {2'b0, r});
   endtask
   task automatic ref_codes();
      logic [7:0] r;
      for (int k = 0; k < 4; k++) begin
         wb(1'b1, adcf_pkg::IDX_MUX_SEL, {k[1:0], 6'h03}, r);
         settle();
         chk("ref_sel", {8'h0, k[1:0]}, {8'h0, rs});
         chk("int_ref", {9'h0, k[1]}, {9'h0, iref});
         chk("ref_pin", {9'h0, k == 3}, {9'h0, rcon});
      end
   endtask
   task automatic uni_codes();
      conv(8'h03, 10'h100);
      conv(8'h20, 10'h000);
      conv(8'h21, 10'h1c0);
      conv(8'ha2, 10'h13a);
      chk("temp_en", 10'h001, {9'h0, ten});
      conv(8'h08, 10'h000);
      conv(8'h28, 10'h040);
      conv(8'h29, 10'h3ff);
      conv(8'h23, 10'h000);
      chk("offset_pins", {2'h0, 4'h0, 4'h0}, {2'h0, pp, np});
      chk("offset_gain", 10'h003, {8'h0, diff, g20});
   endtask
   task automatic bip_codes();
      logic [7:0] r;
      wb(1'b1, adcf_pkg::IDX_CTRL_B, 8'h80, r);
      conv(8'h08, 10'h3e0);
      chk("sign_neg", 10'h001, {9'h0, hi[1]});
      conv(8'h28, 10'h020);
      chk("sign_pos", 10'h000, {9'h0, hi[1]});
      conv(8'h29, 10'h1ff);
      conv(8'h09, 10'h200);
      wb(1'b1, adcf_pkg::IDX_CTRL_B, 8'h00, r);
   endtask
   task automatic defer_sel();
      logic [7:0] r;
      conv(8'h83, 10'h100);
      wb(1'b1, adcf_pkg::IDX_CTRL_A, 8'hd0, r);
      #1;
      chk("start_seen", 10'h003, {8'h0, busy, smp});
      wb(1'b1, adcf_pkg::IDX_MUX_SEL, 8'h47, r);
      wb(1'b0, adcf_pkg::IDX_MUX_SEL, 8'h00, r);
      chk("mux_reg", 10'h047, {2'b0, r});
      #1;
      chk("pin_busy", 10'h003, {6'h0, pp});
      chk("ref_busy", 10'h002, {8'h0, rs});
      start_wait();
      settle();
      chk("pin_after", 10'h007, {6'h0, pp});
      chk("ref_after", 10'h001, {8'h0, rs});
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      reset_vals();
      ref_codes();
      uni_codes();
      bip_codes();
      defer_sel();
      report_and_stop();
   end
endmodule
